// ---- core/abfr_pkg.sv ----
// ----------------------------------------------------------------
// shared constants for the api frame builder
// ----------------------------------------------------------------
package abfr_pkg;
   // register bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DEST_HIGH = 8'h04;
   localparam logic [7:0] REG_DEST_LOW = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control register fields and reset values
   localparam int CTRL_OPT_LSB = 0;
   localparam int CTRL_SHORT_LSB = 16;
   localparam logic [7:0] RST_OPT = 8'h00;
   localparam logic [15:0] RST_SHORT = 16'h0000;
   localparam logic [31:0] RST_DEST = 32'h0000_0000;
   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_FRAMES_LSB = 16;
   localparam int STAT_DROPS_LSB = 24;
   // frame layout
   localparam logic [7:0] START_MARKER = 8'h7e;
   localparam logic [7:0] TYPE_ADDR_UPDATE = 8'h8e;
   localparam logic [7:0] TYPE_RX64 = 8'h80;
   localparam logic [7:0] RESERVED_BYTE = 8'h00;
   localparam logic [7:0] CSUM_BASE = 8'hff;
   localparam int HDR_BYTES = 21;
   localparam int POS_LEN_HI = 1;
   localparam int POS_LEN_LO = 2;
   localparam int POS_TYPE = 3;
   localparam int POS_RESERVED = 4;
   localparam int POS_NEW_ADDR = 5;
   localparam int POS_OLD_ADDR = 13;
   localparam int POS_SRC_ADDR = 4;
   localparam int POS_RSSI = 12;
   localparam int POS_OPTIONS = 13;
   localparam logic [4:0] LAST_ADDR_UPDATE = 5'd20;
   localparam logic [4:0] LAST_RX64 = 5'd13;
   localparam logic [4:0] FIRST_SUMMED = 5'd3;
   localparam logic [15:0] LEN_ADDR_UPDATE = 16'h0012;
   localparam logic [15:0] LEN_RX64_FIXED = 16'h000b;
   // legacy receive output selection
   localparam logic [7:0] OPT_LEGACY = 8'h02;
   localparam logic [15:0] SHORT_ADDR_64BIT = 16'hfffe;
   localparam logic [7:0] RX_OPT_MASK = 8'h06;
   // byte stream buffer
   localparam int FIFO_DEPTH = 8;
   localparam int BYTE_W = 8;
endpackage : abfr_pkg

// ---- core/abfr_stream_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// byte stream carrier between framer and buffer
// ----------------------------------------------------------------
interface abfr_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : abfr_stream_if

// ---- core/abfr_fifo.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// synchronous fifo with valid/ready on both sides
// ----------------------------------------------------------------
module abfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   abfr_stream_if.snk wr,
   abfr_stream_if.src rd
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } abfr_fifo_state_t;

   abfr_fifo_state_t q;
   abfr_fifo_state_t n;
   logic do_wr;
   logic do_rd;

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_bad_param
      $error("abfr_fifo needs a power-of-two depth of at least 2");
   end

   // honest full and empty flags
   assign wr.ready = (q.cnt != DEPTH[PW:0]);
   assign rd.valid = (q.cnt != '0);
   assign rd.data = q.mem[q.rp];
   assign do_wr = wr.valid && wr.ready;
   assign do_rd = rd.valid && rd.ready;

   // next state of storage and pointers
   always_comb
   begin
      n = q;
      if (do_wr)
      begin
         n.mem[q.wp] = wr.data;
         n.wp = q.wp + 1'b1;
      end
      if (do_rd)
      begin
         n.rp = q.rp + 1'b1;
      end
      n.cnt = q.cnt + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd};
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= '0;
      else
         q <= n;
   end
endmodule : abfr_fifo

// ---- core/abfr_frame_builder.sv ----
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - every frame opens with one start-marker byte at position 0.
// - bytes 1 and 2 hold the count of bytes between length field and checksum.
// - the last byte is 0xff minus the low byte of the sum of bytes from position 3 on.
// - an address-update frame carries type 0x8e at position 3.
// - position 4 of an address-update frame is always zero.
// - positions 5 to 12 of an address-update frame hold the new destination address.
// - positions 13 to 20 of an address-update frame hold the old destination address.
// - a receive frame goes out only with output option 2 and short address 0xfffe.
// - the receive frame carries type 0x80 at position 3.
// - positions 4 to 11 of the receive frame hold the sender's 64-bit address.
// - position 12 holds signal strength as the magnitude of the negative dbm level.
// - position 13 holds option flags: bit 1 broadcast, bit 2 cross-pan broadcast.
// - the radio payload runs from position 14 up to the checksum byte.
// - a matching aggregator request rewrites the destination and then emits the update.
module abfr_frame_builder #(
   parameter int DEPTH = abfr_pkg::FIFO_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite register slave
   input wire logic [abfr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [abfr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // aggregator address-update request
   input wire logic aggregator_request,
   output logic agg_ready,
   input wire logic [63:0] agg_match_addr,
   input wire logic [63:0] agg_new_addr,
   // received packet descriptor
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [63:0] rx_src_addr,
   input wire logic [7:0] rx_rssi,
   input wire logic [7:0] rx_options,
   input wire logic [15:0] rx_len,
   // received payload bytes
   input wire logic pl_valid,
   output logic pl_ready,
   input wire logic [7:0] pl_data,
   // serial api byte stream to the host
   output logic api_valid,
   input wire logic api_ready,
   output logic [7:0] api_data
);
   import abfr_pkg::*;

   // ----------------------------------------------------------------
   // types and state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR = 3'b001,
      ST_PAYLOAD = 3'b010,
      ST_CSUM = 3'b011,
      ST_DRAIN = 3'b100
   } abfr_st_t;

   typedef logic [HDR_BYTES-1:0][7:0] abfr_hdr_t;

   typedef struct packed {
      abfr_st_t st;
      logic [7:0] opt;
      logic [15:0] short_addr;
      logic [31:0] dest_addr_high;
      logic [31:0] dest_addr_low;
      logic aw_ok;
      logic [ADDR_W-1:0] awaddr;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      abfr_hdr_t hdr;
      logic [4:0] hdr_last;
      logic [4:0] idx;
      logic [15:0] pl_left;
      logic [7:0] sum;
      logic is_agg;
      logic [7:0] frames;
      logic [7:0] drops;
   } abfr_state_t;

   abfr_state_t q;
   abfr_state_t n;
   abfr_stream_if #(.WIDTH(BYTE_W)) push_if ();
   abfr_stream_if #(.WIDTH(BYTE_W)) out_if ();
   logic rx_enabled;
   logic agg_match;
   logic [31:0] ctrl_merged;

   if (DEPTH < 2)
   begin : g_bad_depth
      $error("abfr_frame_builder needs a buffer depth of at least 2");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // place a 64-bit address most significant byte first
   function automatic abfr_hdr_t put_addr(abfr_hdr_t h, int pos, logic [63:0] a);
      abfr_hdr_t r;
      r = h;
      for (int i = 0; i < 8; i++)
      begin
         r[pos + i] = a[63 - 8 * i -: 8];
      end
      return r;
   endfunction : put_addr

   // merge write data under byte strobes
   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            r[8 * i +: 8] = d[8 * i +: 8];
      end
      return r;
   endfunction : merge

   // check byte from a running sum
   function automatic logic [7:0] csum_of(logic [7:0] s);
      return CSUM_BASE - s;
   endfunction : csum_of

   // ----------------------------------------------------------------
   // handshakes and outputs
   // ----------------------------------------------------------------
   // legacy receive output selection and aggregator match
   assign rx_enabled = (q.opt == OPT_LEGACY) && (q.short_addr == SHORT_ADDR_64BIT);
   assign agg_match = ({q.dest_addr_high, q.dest_addr_low} == agg_match_addr);
   // control word under byte strobes, fields at their register positions
   assign ctrl_merged = merge({q.short_addr, 8'h00, q.opt}, q.wdata, q.wstrb);
   assign s_axi_awready = !q.aw_ok && !q.bvalid;
   assign s_axi_wready = !q.w_ok && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign agg_ready = (q.st == ST_IDLE);
   assign rx_ready = (q.st == ST_IDLE) && !aggregator_request;
   assign api_valid = out_if.valid;
   assign api_data = out_if.data;
   assign out_if.ready = api_ready;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      n = q;
      push_if.valid = 1'b0;
      push_if.data = '0;
      pl_ready = 1'b0;
      // write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         n.aw_ok = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         n.w_ok = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (q.aw_ok && q.w_ok)
      begin
         n.aw_ok = 1'b0;
         n.w_ok = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         case (q.awaddr)
            REG_CTRL:
            begin
               n.opt = ctrl_merged[CTRL_OPT_LSB +: 8];
               n.short_addr = ctrl_merged[CTRL_SHORT_LSB +: 16];
            end
            REG_DEST_HIGH: n.dest_addr_high = merge(q.dest_addr_high, q.wdata, q.wstrb);
            REG_DEST_LOW: n.dest_addr_low = merge(q.dest_addr_low, q.wdata, q.wstrb);
            REG_STATUS: n.bresp = RESP_OKAY;
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      // read answer one cycle after the address is taken
      if (q.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = '0;
         case (s_axi_araddr)
            REG_CTRL:
            begin
               n.rdata[CTRL_OPT_LSB +: 8] = q.opt;
               n.rdata[CTRL_SHORT_LSB +: 16] = q.short_addr;
            end
            REG_DEST_HIGH: n.rdata = q.dest_addr_high;
            REG_DEST_LOW: n.rdata = q.dest_addr_low;
            REG_STATUS:
            begin
               n.rdata[STAT_BUSY_BIT] = (q.st != ST_IDLE);
               n.rdata[STAT_FRAMES_LSB +: 8] = q.frames;
               n.rdata[STAT_DROPS_LSB +: 8] = q.drops;
            end
            default: n.rresp = RESP_SLVERR;
         endcase
      end
      // frame sequencer
      unique case (q.st)
         ST_IDLE:
         begin
            n.idx = '0;
            n.sum = '0;
            n.hdr = '0;
            n.hdr[0] = START_MARKER;
            if (aggregator_request)
            begin
               if (agg_match)
               begin
                  // hardware update wins over a software write in the same cycle
                  {n.dest_addr_high, n.dest_addr_low} = agg_new_addr;
                  n.hdr[POS_LEN_HI] = LEN_ADDR_UPDATE[15:8];
                  n.hdr[POS_LEN_LO] = LEN_ADDR_UPDATE[7:0];
                  n.hdr[POS_TYPE] = TYPE_ADDR_UPDATE;
                  n.hdr[POS_RESERVED] = RESERVED_BYTE;
                  n.hdr = put_addr(n.hdr, POS_NEW_ADDR, agg_new_addr);
                  n.hdr = put_addr(n.hdr, POS_OLD_ADDR,
                     {q.dest_addr_high, q.dest_addr_low});
                  n.hdr_last = LAST_ADDR_UPDATE;
                  n.pl_left = '0;
                  n.is_agg = 1'b1;
                  n.st = ST_HDR;
               end
            end
            else if (rx_valid)
            begin
               n.pl_left = rx_len;
               n.is_agg = 1'b0;
               if (rx_enabled)
               begin
                  n.hdr[POS_LEN_HI] = 8'(({8'h00, LEN_RX64_FIXED} + {8'h00, rx_len}) >> 8);
                  n.hdr[POS_LEN_LO] = LEN_RX64_FIXED[7:0] + rx_len[7:0];
                  n.hdr[POS_TYPE] = TYPE_RX64;
                  n.hdr = put_addr(n.hdr, POS_SRC_ADDR, rx_src_addr);
                  n.hdr[POS_RSSI] = rx_rssi;
                  n.hdr[POS_OPTIONS] = rx_options & RX_OPT_MASK;
                  n.hdr_last = LAST_RX64;
                  n.st = ST_HDR;
               end
               else
               begin
                  // payload of a filtered packet is consumed and discarded
                  n.drops = q.drops + 8'h01;
                  n.st = (rx_len != '0) ? ST_DRAIN : ST_IDLE;
               end
            end
         end
         ST_HDR:
         begin
            push_if.valid = 1'b1;
            push_if.data = q.hdr[q.idx];
            if (push_if.ready)
            begin
               if (q.idx >= FIRST_SUMMED)
                  n.sum = q.sum + q.hdr[q.idx];
               if (q.idx == q.hdr_last)
                  n.st = (q.pl_left != '0) ? ST_PAYLOAD : ST_CSUM;
               else
                  n.idx = q.idx + 5'd1;
            end
         end
         ST_PAYLOAD:
         begin
            // payload passes through unchanged up to the check byte
            push_if.valid = pl_valid;
            push_if.data = pl_data;
            pl_ready = push_if.ready;
            if (pl_valid && push_if.ready)
            begin
               n.sum = q.sum + pl_data;
               n.pl_left = q.pl_left - 16'h0001;
               if (q.pl_left == 16'h0001)
                  n.st = ST_CSUM;
            end
         end
         ST_CSUM:
         begin
            push_if.valid = 1'b1;
            push_if.data = csum_of(q.sum);
            if (push_if.ready)
            begin
               n.frames = q.frames + 8'h01;
               n.st = ST_IDLE;
            end
         end
         ST_DRAIN:
         begin
            pl_ready = 1'b1;
            if (pl_valid)
            begin
               n.pl_left = q.pl_left - 16'h0001;
               if (q.pl_left == 16'h0001)
                  n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.opt <= RST_OPT;
         q.short_addr <= RST_SHORT;
         q.dest_addr_high <= RST_DEST;
         q.dest_addr_low <= RST_DEST;
         q.st <= ST_IDLE;
      end
      else
         q <= n;
   end

   // ----------------------------------------------------------------
   // output byte buffer
   // ----------------------------------------------------------------
   abfr_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr(push_if.snk),
      .rd(out_if.src)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic push_take;
   assign push_take = push_if.valid && push_if.ready;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_start_marker: assert property (
      push_take && q.st == ST_HDR && q.idx == 5'd0 |-> push_if.data == START_MARKER)
      else $error("frame did not open with the start marker");
   chk_length_field: assert property (
      push_take && q.st == ST_HDR && q.is_agg && q.idx == 5'd2
      |-> push_if.data == LEN_ADDR_UPDATE[7:0])
      else $error("address-update length byte wrong");
   chk_check_byte: assert property (
      push_take && q.st == ST_CSUM |-> push_if.data == CSUM_BASE - q.sum ##1 q.st == ST_IDLE)
      else $error("check byte wrong or frame not closed");
   chk_update_type: assert property (
      push_take && q.st == ST_HDR && q.is_agg && q.idx == 5'd3
      |-> push_if.data == TYPE_ADDR_UPDATE)
      else $error("address-update type code wrong");
   chk_reserved_zero: assert property (
      push_take && q.st == ST_HDR && q.is_agg && q.idx == 5'd4 |-> push_if.data == 8'h00)
      else $error("reserved byte not zero");
   chk_dest_rewrite: assert property (
      q.st == ST_IDLE && aggregator_request && agg_match
      |=> {q.dest_addr_high, q.dest_addr_low} == $past(agg_new_addr)
          && q.hdr[POS_OLD_ADDR] == $past(agg_match_addr[63:56]) && q.st == ST_HDR)
      else $error("destination not rewritten on matching request");
   chk_rx_filter: assert property (
      q.st == ST_IDLE && rx_valid && rx_ready && !rx_enabled |=> q.st != ST_HDR)
      else $error("receive frame emitted while not selected");
   chk_rx_type: assert property (
      push_take && q.st == ST_HDR && !q.is_agg && q.idx == 5'd3 |-> push_if.data == TYPE_RX64)
      else $error("receive type code wrong");
   chk_payload_pass: assert property (
      q.st == ST_PAYLOAD && pl_valid && pl_ready |-> push_take && push_if.data == pl_data)
      else $error("payload byte altered");

   cov_update_frame: cover property (q.st == ST_CSUM && q.is_agg ##1 q.st == ST_IDLE);
   cov_rx_frame: cover property (q.st == ST_PAYLOAD ##[1:50] q.st == ST_CSUM);
   cov_rx_dropped: cover property (q.st == ST_DRAIN);
   cov_stall: cover property (push_if.valid && !push_if.ready);
endmodule : abfr_frame_builder

// ---- dv/abfr_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host reading the serial api stream
// ----------------------------------------------------------------
module abfr_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stall,
   input wire logic api_valid,
   input wire logic [7:0] api_data,
   output logic api_ready,
   output logic got,
   output logic [7:0] got_byte
);
   // ready drops while the host stalls, so the buffer backs up
   always_ff @(posedge aclk)
   begin
      api_ready <= aresetn && !stall;
   end
   // a byte is taken on every edge with valid and ready
   assign got = api_valid && api_ready;
   assign got_byte = api_data;
endmodule : abfr_host_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench for the api frame builder
// ----------------------------------------------------------------
`define CHK(nm, e, g) \
   begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
   import abfr_pkg::*;
   localparam int LIM = 1000;
   logic aclk = 0, aresetn = 0, stall = 0, got;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pl_data = 0, rx_rssi = 0, rx_options = 0;
   logic [7:0] api_data, got_byte, eb;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [63:0] agg_match_addr = 0, agg_new_addr = 0, rx_src_addr = 0;
   logic [15:0] rx_len = 0, seed = 16'h000f;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, aggregator_request = 0, rx_valid = 0, pl_valid = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic agg_ready, rx_ready, pl_ready, api_valid, api_ready;
   int n_errors = 0, cmp_count = 0;
   logic [7:0] exp_q[$];
   logic [7:0] pl_q[$];
   always #5 aclk = ~aclk;
   abfr_frame_builder dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aggregator_request, .agg_ready,
      .agg_match_addr, .agg_new_addr, .rx_valid, .rx_ready, .rx_src_addr, .rx_rssi,
      .rx_options, .rx_len, .pl_valid, .pl_ready, .pl_data, .api_valid, .api_ready, .api_data);
   abfr_host_model host (.aclk, .aresetn, .stall, .api_valid, .api_data, .api_ready, .got,
      .got_byte);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // random host stalls
   always @(posedge aclk)
   begin
      seed <= lfsr(seed);
      stall <= seed[2] & seed[5];
   end
   // each byte the host takes must be the next expected one
   always @(posedge aclk)
   begin
      if (got)
      begin
         eb = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         `CHK("api byte", eb, got_byte)
      end
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   task automatic bound(input int n);
      if (n >= LIM)
      begin
         n_errors++;
         $display("[ERR] wait exp done got timeout");
         finish_test();
      end
   endtask : bound
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
         n++;
      end
      while (!s_axi_bvalid && n < LIM);
      bound(n);
      `CHK("write resp", r, s_axi_bresp)
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
         n++;
      end
      while (!s_axi_rvalid && n < LIM);
      bound(n);
      `CHK("read data", d, s_axi_rdata)
      `CHK("read resp", r, s_axi_rresp)
   endtask : axr
   // model: marker, length, type, body, check byte
   task automatic exp_frame(input logic [7:0] ty, input logic [7:0] b[$]);
      int s = ty;
      exp_q.push_back(8'h7e);
      exp_q.push_back(8'((b.size() + 1) >> 8));
      exp_q.push_back(8'(b.size() + 1));
      exp_q.push_back(ty);
      foreach (b[i])
      begin
         exp_q.push_back(b[i]);
         s += b[i];
      end
      exp_q.push_back(8'(255 - s));
   endtask : exp_frame
   task automatic agg(input logic [63:0] m, input logic [63:0] nw, input bit hit);
      logic [7:0] b[$];
      logic [127:0] both;
      int n = 0;
      both = {nw, m};
      b = {8'h00};
      for (int i = 15; i >= 0; i--)
         b.push_back(both[i*8 +: 8]);
      if (hit)
         exp_frame(8'h8e, b);
      agg_match_addr <= m;
      agg_new_addr <= nw;
      aggregator_request <= 1;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!agg_ready && n < LIM);
      aggregator_request <= 0;
      bound(n);
   endtask : agg
   task automatic rx(input logic [7:0] opt, input int len, input bit hit);
      logic [7:0] b[$];
      logic [63:0] src;
      int n = 0;
      src = {4{seed}} ^ 64'h0123456789abcdef;
      b = {};
      for (int i = 7; i >= 0; i--)
         b.push_back(src[i*8 +: 8]);
      b.push_back(8'h28);
      b.push_back(opt & 8'h06);
      pl_q = {};
      for (int i = 0; i < len; i++)
         pl_q.push_back(8'(seed + i * 37));
      b = {b, pl_q};
      if (hit)
         exp_frame(8'h80, b);
      rx_src_addr <= src;
      rx_rssi <= 8'h28;
      rx_options <= opt;
      rx_len <= 16'(len);
      rx_valid <= 1;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (!rx_ready && n < LIM);
      rx_valid <= 0;
      foreach (pl_q[i])
      begin
         pl_data <= pl_q[i];
         pl_valid <= 1;
         do
         begin
            @(posedge aclk);
            n++;
         end
         while (!pl_ready && n < LIM);
      end
      pl_valid <= 0;
      // let an edge pass so a following call never re-raises rx_valid at once
      @(posedge aclk);
      bound(n);
   endtask : rx
   task automatic drain(input string s);
      int n = 0;
      while (exp_q.size() > 0 && n < LIM)
      begin
         @(posedge aclk);
         n++;
      end
      bound(n);
      repeat (30) @(posedge aclk);
      $display("test %s done", s);
   endtask : drain
   // main sequence
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      axr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
      axr(REG_DEST_LOW, 32'h0000_0000, RESP_OKAY);
      axr(8'h20, 32'h0000_0000, RESP_SLVERR);
      axw(8'h20, 32'h1111_1111, RESP_SLVERR);
      axw(REG_DEST_HIGH, 32'h0013_a200, RESP_OKAY);
      axw(REG_DEST_LOW, 32'h4052_aaaa, RESP_OKAY);
      agg(64'h0013a200_4052aaaa, 64'h0013a200_4052bbbb, 1);
      drain("address update");
      axr(REG_DEST_LOW, 32'h4052_bbbb, RESP_OKAY);
      agg(64'h0013a200_4052aaaa, 64'h0000_0001, 0);
      drain("stale request");
      axr(REG_DEST_LOW, 32'h4052_bbbb, RESP_OKAY);
      rx(8'h02, 3, 0);
      drain("option off");
      axw(REG_CTRL, 32'hfffe_0002, RESP_OKAY);
      for (int i = 0; i < 8; i++)
         rx(8'(i), (i * 3) % 7, 1);
      agg(64'h0013a200_4052bbbb, 64'hfedcba98_76543210, 1);
      drain("legacy receive");
      axw(REG_CTRL, 32'h1234_0002, RESP_OKAY);
      rx(8'h02, 2, 0);
      drain("short address");
      // byte strobes merge into the old word
      s_axi_wstrb <= 4'h3;
      axw(REG_DEST_HIGH, 32'hffff_5555, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axr(REG_DEST_HIGH, 32'hfedc_5555, RESP_OKAY);
      axr(REG_STATUS, 32'h020a_0000, RESP_OKAY);
      finish_test();
   end
endmodule : testbench
